// [core/pin_sync.sv]
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the inputs are levels that stay put for several clocks;
  the first stage is read only by the second.
*/
`timescale 1ns/1ps

module pin_sync #(
  parameter int           WIDTH   = 1,
  parameter logic [31:0]  RST_VAL = 32'h0000_0000
) (
  input  wire logic             clk,      // core clock
  input  wire logic             arst_n,   // async reset, active low
  input  wire logic             ce,       // clock enable
  input  wire logic [WIDTH-1:0] pin_in,   // raw asynchronous level
  output logic      [WIDTH-1:0] sync_out  // level in clk domain
);

  logic [WIDTH-1:0] meta;

  // stage one feeds stage two only, keeping metastability contained
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= RST_VAL[WIDTH-1:0];
      sync_out <= RST_VAL[WIDTH-1:0];
    end else if (ce) begin
      meta     <= pin_in;
      sync_out <= meta;
    end
  end

endmodule

// [core/pot_terminal_control_regs.sv]
/*
  Terminal-control register logic of a quad digital potentiometer.
  Holds the two terminal control registers, checks each decoded serial
  command against the memory map, keeps the command error state and
  drives the connect and forced-shutdown controls of all four networks.
  Assumes a serial front end on clk that hands over one decoded command
  per cmd_valid pulse and pulses cmd_end once the whole command is done;
  chip select and the reset pin come straight from pins.
*/
`timescale 1ns/1ps

module pot_terminal_control_regs (
  input  wire logic       clk,                   // core clock, 200 MHz
  input  wire logic       arst_n,                // power-on/brown-out reset, low
  input  wire logic       ce,                    // clock enable, freezes state
  input  wire logic       reset_pin_n,           // external reset pin, async
  input  wire logic       cs_pin_n,              // chip select pin, async
  input  wire logic       cmd_valid,             // decoded command pulse
  input  wire logic [3:0] cmd_addr,              // memory address
  input  wire logic [1:0] cmd_op,                // command kind
  input  wire logic [8:0] cmd_wdata,             // write data
  input  wire logic       cmd_end,               // command fully completed
  output logic            rd_valid,              // read data pulse
  output logic      [8:0] rd_data,               // read data
  output logic            cmd_error,             // command error state
  output logic            net0_term_a_connect,   // network 0 terminal A switch
  output logic            net0_wiper_connect,    // network 0 wiper switch
  output logic            net0_term_b_connect,   // network 0 terminal B switch
  output logic            net0_force_shutdown_n, // network 0 forced shutdown, low
  output logic            net1_term_a_connect,   // network 1 terminal A switch
  output logic            net1_wiper_connect,    // network 1 wiper switch
  output logic            net1_term_b_connect,   // network 1 terminal B switch
  output logic            net1_force_shutdown_n, // network 1 forced shutdown, low
  output logic            net2_term_a_connect,   // network 2 terminal A switch
  output logic            net2_wiper_connect,    // network 2 wiper switch
  output logic            net2_term_b_connect,   // network 2 terminal B switch
  output logic            net2_force_shutdown_n, // network 2 forced shutdown, low
  output logic            net3_term_a_connect,   // network 3 terminal A switch
  output logic            net3_wiper_connect,    // network 3 wiper switch
  output logic            net3_term_b_connect,   // network 3 terminal B switch
  output logic            net3_force_shutdown_n  // network 3 forced shutdown, low
);

  //////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the address is one of the two terminal control registers
  function automatic logic addr_is_terminal_ctrl_reg(input logic [3:0] addr);
    addr_is_terminal_ctrl_reg = (addr == pot_terminal_ctrl_reg_pkg::ADDR_TCTRL0) ||
                   (addr == pot_terminal_ctrl_reg_pkg::ADDR_TCTRL1);
  endfunction

  // wiper locations accept every command kind
  function automatic logic addr_is_wiper(input logic [3:0] addr);
    addr_is_wiper = (addr == pot_terminal_ctrl_reg_pkg::ADDR_WIPER0) ||
                    (addr == pot_terminal_ctrl_reg_pkg::ADDR_WIPER1) ||
                    (addr == pot_terminal_ctrl_reg_pkg::ADDR_WIPER2) ||
                    (addr == pot_terminal_ctrl_reg_pkg::ADDR_WIPER3);
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic reset_pin_sync_n;
  logic cs_sync_n;

  // both pins idle high; reset value matches a released pin
  pin_sync #(
    .WIDTH   (2),
    .RST_VAL (32'h0000_0003)
  ) u_pin_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .ce       (ce),
    .pin_in   ({reset_pin_n, cs_pin_n}),
    .sync_out ({reset_pin_sync_n, cs_sync_n})
  );

  //////////////////////////////////////////////////////////////////////
  // command qualification

  logic       in_reset;
  logic       serial_enabled;
  logic       accept;
  logic       is_terminal_ctrl_reg;
  logic       is_wiper;
  logic       op_is_write;
  logic       op_is_read;
  logic       op_is_step;
  logic       allowed;
  logic       set_error;
  logic       clear_error;
  logic       good_cmd;
  logic       next_cmd_error;

  // the reset pin holds the serial side off until it is released
  assign in_reset       = !reset_pin_sync_n;
  assign serial_enabled = !in_reset;

  // a command in error state is dropped; it never touches a register
  assign accept         = cmd_valid && serial_enabled && !cmd_error;

  assign is_terminal_ctrl_reg        = addr_is_terminal_ctrl_reg(cmd_addr);
  assign is_wiper       = addr_is_wiper(cmd_addr);
  assign op_is_write    = (cmd_op == pot_terminal_ctrl_reg_pkg::OP_WRITE);
  assign op_is_read     = (cmd_op == pot_terminal_ctrl_reg_pkg::OP_READ);
  assign op_is_step     = (cmd_op == pot_terminal_ctrl_reg_pkg::OP_INCR) ||
                          (cmd_op == pot_terminal_ctrl_reg_pkg::OP_DECR);

  // terminal control takes read and write only; reserved takes nothing
  assign allowed        = is_wiper ||
                          (is_terminal_ctrl_reg && (op_is_write || op_is_read)) ||
                          (is_terminal_ctrl_reg && !op_is_step && !op_is_write && !op_is_read);
  assign set_error      = accept && !allowed;
  assign good_cmd       = accept && allowed;

  // a return of chip select to its inactive level, or the reset pin, leaves the error
  assign clear_error    = cs_sync_n || in_reset;
  // a new fault in the clearing cycle wins over the clear
  assign next_cmd_error = set_error || (cmd_error && !clear_error);

  // error state flip-flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_error <= 1'b0;
    end else if (ce) begin
      cmd_error <= next_cmd_error;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // the two terminal control registers

  localparam logic [3:0] TERMINAL_CTRL_REG_ADDR [2] = '{pot_terminal_ctrl_reg_pkg::ADDR_TCTRL0,
                                           pot_terminal_ctrl_reg_pkg::ADDR_TCTRL1};

  logic [7:0] terminal_ctrl_reg_applied [2];
  logic [1:0] terminal_ctrl_reg_stage;
  logic       cmd_drop;

  // a frame that ends without completing its command loses its data
  assign cmd_drop = cs_sync_n && !cmd_end;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_terminal_ctrl_reg
      // only the eight control bits are stored; bit 8 is dropped here
      assign terminal_ctrl_reg_stage[g] = good_cmd && op_is_write &&
                             (cmd_addr == TERMINAL_CTRL_REG_ADDR[g]);

      terminal_ctrl_reg_stage_reg #(
        .W (pot_terminal_ctrl_reg_pkg::CTRL_W)
      ) u_terminal_ctrl_reg (
        .clk           (clk),
        .arst_n        (arst_n),
        .ce            (ce),
        .force_default (in_reset),
        .stage         (terminal_ctrl_reg_stage[g]),
        .stage_value   (cmd_wdata[7:0]),
        .commit        (cmd_end),
        .drop          (cmd_drop),
        .applied       (terminal_ctrl_reg_applied[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // read path

  logic [8:0] read_value;
  logic       rd_fire;

  // bit 8 is not stored and always reads back as one; wipers live elsewhere
  assign read_value = (cmd_addr == pot_terminal_ctrl_reg_pkg::ADDR_TCTRL0) ?
                        {1'b1, terminal_ctrl_reg_applied[0]} :
                      (cmd_addr == pot_terminal_ctrl_reg_pkg::ADDR_TCTRL1) ?
                        {1'b1, terminal_ctrl_reg_applied[1]} :
                        9'h000;
  assign rd_fire    = good_cmd && op_is_read;

  // read answer register, one-cycle strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data  <= 9'h000;
    end else if (ce) begin
      rd_valid <= rd_fire;
      if (rd_fire) begin
        rd_data <= read_value;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // terminal switch controls, one flop per terminal

  logic [3:0] term_a;
  logic [3:0] wiper;
  logic [3:0] term_b;
  logic [3:0] shut_n;

  // no wiper value is read or written here, so wiper codes stay put
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_net
      assign term_a[n] = terminal_ctrl_reg_applied[n/2][(n%2)*pot_terminal_ctrl_reg_pkg::FLD_W +
                                           pot_terminal_ctrl_reg_pkg::FLD_TERM_A];
      assign wiper[n]  = terminal_ctrl_reg_applied[n/2][(n%2)*pot_terminal_ctrl_reg_pkg::FLD_W +
                                           pot_terminal_ctrl_reg_pkg::FLD_WIPER];
      assign term_b[n] = terminal_ctrl_reg_applied[n/2][(n%2)*pot_terminal_ctrl_reg_pkg::FLD_W +
                                           pot_terminal_ctrl_reg_pkg::FLD_TERM_B];
      assign shut_n[n] = terminal_ctrl_reg_applied[n/2][(n%2)*pot_terminal_ctrl_reg_pkg::FLD_W +
                                           pot_terminal_ctrl_reg_pkg::FLD_SHUTDOWN_N];
    end
  endgenerate

  // output register adds one cycle after the applied value changes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {net1_force_shutdown_n, net1_term_a_connect,
       net1_wiper_connect, net1_term_b_connect}   <= 4'hF;
      {net0_force_shutdown_n, net0_term_a_connect,
       net0_wiper_connect, net0_term_b_connect}   <= 4'hF;
      {net3_force_shutdown_n, net3_term_a_connect,
       net3_wiper_connect, net3_term_b_connect}   <= 4'hF;
      {net2_force_shutdown_n, net2_term_a_connect,
       net2_wiper_connect, net2_term_b_connect}   <= 4'hF;
    end else if (ce) begin
      net1_force_shutdown_n <= shut_n[1];
      net1_term_a_connect   <= term_a[1];
      net1_wiper_connect    <= wiper[1];
      net1_term_b_connect   <= term_b[1];
      net0_force_shutdown_n <= shut_n[0];
      net0_term_a_connect   <= term_a[0];
      net0_wiper_connect    <= wiper[0];
      net0_term_b_connect   <= term_b[0];
      net3_force_shutdown_n <= shut_n[3];
      net3_term_a_connect   <= term_a[3];
      net3_wiper_connect    <= wiper[3];
      net3_term_b_connect   <= term_b[3];
      net2_force_shutdown_n <= shut_n[2];
      net2_term_a_connect   <= term_a[2];
      net2_wiper_connect    <= wiper[2];
      net2_term_b_connect   <= term_b[2];
    end
  end

endmodule

// [core/pot_terminal_ctrl_reg_pkg.sv]
/*
  Constants for the terminal-control register logic of a quad
  digital potentiometer: memory-map addresses, command codes, field
  positions and values after reset.
  Assumes nothing; it is shared by the design files under core/ other than the pin synchroniser.
*/
package pot_terminal_ctrl_reg_pkg;

  // memory map: 16 locations, 4-bit address
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  ADDR_WIPER0     = 4'h0;
  localparam logic [3:0]  ADDR_WIPER1     = 4'h1;
  localparam logic [3:0]  ADDR_TCTRL0     = 4'h4;
  localparam logic [3:0]  ADDR_WIPER2     = 4'h6;
  localparam logic [3:0]  ADDR_WIPER3     = 4'h7;
  localparam logic [3:0]  ADDR_TCTRL1     = 4'hA;

  // register width and layout
  localparam int          REG_W           = 9;
  localparam int          CTRL_W          = 8;
  localparam int          BIT_RESERVED    = 8;
  localparam logic [8:0]  TCTRL_RESET      = 9'h1FF;
  localparam logic [7:0]  TCTRL_BITS_RESET = 8'hFF;

  // bit positions within one 4-bit network field
  localparam int          FLD_TERM_B      = 0;
  localparam int          FLD_WIPER       = 1;
  localparam int          FLD_TERM_A      = 2;
  localparam int          FLD_SHUTDOWN_N  = 3;
  localparam int          FLD_W           = 4;

  // serial command kinds as decoded by the front end
  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_INCR  = 2'b01,
    OP_DECR  = 2'b10,
    OP_READ  = 2'b11
  } cmd_op_t;

  // synchroniser depth for pins
  localparam int          SYNC_STAGES     = 2;

endpackage

// [core/terminal_ctrl_reg_stage_reg.sv]
/*
  One terminal-control register: a staged value taken during a write
  command and an applied value that drives the terminal switches.
  Assumes the caller pulses commit when the serial command has ended
  and holds force_default while the device sits in reset.
*/
`timescale 1ns/1ps

module terminal_ctrl_reg_stage_reg #(
  parameter int W = pot_terminal_ctrl_reg_pkg::CTRL_W
) (
  input  wire logic         clk,           // core clock
  input  wire logic         arst_n,        // async reset, active low
  input  wire logic         ce,            // clock enable
  input  wire logic         force_default, // reset pin held low
  input  wire logic         stage,         // accepted write to this register
  input  wire logic [W-1:0] stage_value,   // control bits to stage
  input  wire logic         commit,        // serial command completed
  input  wire logic         drop,          // command aborted, discard stage
  output logic      [W-1:0] applied        // value on the switches
);

  logic [W-1:0] staged;
  logic         staged_valid;

  // the staged copy keeps the switches steady while a transfer runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      staged       <= pot_terminal_ctrl_reg_pkg::TCTRL_BITS_RESET[W-1:0];
      staged_valid <= 1'b0;
    end else if (ce) begin
      if (force_default || drop || commit) begin
        staged_valid <= 1'b0;
      end else if (stage) begin
        staged       <= stage_value;
        staged_valid <= 1'b1;
      end
    end
  end

  // applied value changes only at command completion, while force_default is held, or on arst_n
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      applied <= pot_terminal_ctrl_reg_pkg::TCTRL_BITS_RESET[W-1:0];
    end else if (ce) begin
      if (force_default) begin
        applied <= pot_terminal_ctrl_reg_pkg::TCTRL_BITS_RESET[W-1:0];
      end else if (commit && staged_valid) begin
        applied <= staged;
      end
    end
  end

endmodule

// [verif/host_ctrl_model.sv]
/*
  Host controller model: issues decoded commands and works chip select.
  Assumes the bench calls its tasks; everything moves just after a rising edge.
*/
`timescale 1ns/1ps

module host_ctrl_model (
  input  wire logic clk,       // core clock
  output logic      cs_pin_n,  // chip select, low
  output logic      cmd_valid, // command strobe
  output logic      cmd_end,   // command completed
  output logic [3:0] cmd_addr, // address
  output logic [1:0] cmd_op,   // command kind
  output logic [8:0] cmd_wdata // write data
);
  // idle fields never repeat the last value, so stale data cannot pass
  initial begin
    cs_pin_n  = 1'b0;
    cmd_valid = 1'b0;
    cmd_end   = 1'b0;
    cmd_addr  = 4'hF;
    cmd_op    = 2'b00;
    cmd_wdata = 9'h155;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one command, then gap idle cycles before the completion pulse
  task automatic send(input logic [3:0] a, input logic [1:0] op, input logic [8:0] d,
                      input int gap);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_addr  <= a;
    cmd_op    <= op;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_addr  <= ~a;
    cmd_op    <= ~op;
    cmd_wdata <= ~d;
    repeat (gap) @(posedge clk);
    cmd_end <= 1'b1;
    @(posedge clk);
    cmd_end <= 1'b0;
  endtask

  // deselect long enough for the synchroniser, then select again
  task automatic clear_err;
    @(posedge clk);
    cs_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_pin_n <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // after a device reset the host puts its settings back
  task automatic restore(input logic [8:0] v0, input logic [8:0] v1);
    send(4'h4, 2'b00, v0, 0);
    send(4'hA, 2'b00, v1, 0);
  endtask
endmodule

// [verif/pot_terminal_control_regs_tb.sv]
/*
  Self-checking bench for the terminal-control register block.
  Assumes host_ctrl_model drives the command port and chip select.
*/
`timescale 1ns/1ps

module pot_terminal_control_regs_tb;
  logic       clk = 1'b0, arst_n = 1'b0, ce = 1'b1, reset_pin_n = 1'b1;
  logic       cs_pin_n, cmd_valid, cmd_end, rd_valid, cmd_error;
  logic [3:0] cmd_addr;
  logic [1:0] cmd_op;
  logic [8:0] cmd_wdata, rd_data, last_rd;
  logic       net0_term_a_connect, net0_wiper_connect, net0_term_b_connect;
  logic       net0_force_shutdown_n, net1_term_a_connect, net1_wiper_connect;
  logic       net1_term_b_connect, net1_force_shutdown_n, net2_term_a_connect;
  logic       net2_wiper_connect, net2_term_b_connect, net2_force_shutdown_n;
  logic       net3_term_a_connect, net3_wiper_connect, net3_term_b_connect;
  logic       net3_force_shutdown_n;
  int         miscompares = 0, num_checks = 0, rd_seen = 0;
  wire logic [15:0] outs = {net3_force_shutdown_n, net3_term_a_connect, net3_wiper_connect,
    net3_term_b_connect, net2_force_shutdown_n, net2_term_a_connect, net2_wiper_connect,
    net2_term_b_connect, net1_force_shutdown_n, net1_term_a_connect, net1_wiper_connect,
    net1_term_b_connect, net0_force_shutdown_n, net0_term_a_connect, net0_wiper_connect,
    net0_term_b_connect};

  always #2.5 clk = ~clk;

  pot_terminal_control_regs dut (.clk, .arst_n, .ce, .reset_pin_n, .cs_pin_n, .cmd_valid,
    .cmd_addr, .cmd_op, .cmd_wdata, .cmd_end, .rd_valid, .rd_data, .cmd_error,
    .net0_term_a_connect, .net0_wiper_connect, .net0_term_b_connect, .net0_force_shutdown_n,
    .net1_term_a_connect, .net1_wiper_connect, .net1_term_b_connect, .net1_force_shutdown_n,
    .net2_term_a_connect, .net2_wiper_connect, .net2_term_b_connect, .net2_force_shutdown_n,
    .net3_term_a_connect, .net3_wiper_connect, .net3_term_b_connect, .net3_force_shutdown_n);
  host_ctrl_model host (.clk, .cs_pin_n, .cmd_valid, .cmd_end, .cmd_addr, .cmd_op, .cmd_wdata);

  // catch every read pulse; it lasts one cycle, before the command task returns
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      last_rd <= rd_data;
      rd_seen <= rd_seen + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // exactly one answer per read
  task automatic rd(input logic [3:0] a, input logic [8:0] exp);
    int n;
    n = rd_seen;
    host.send(a, 2'b11, 9'h000, 0);
    tick(1);
    chk("read count", 16'(n + 1), 16'(rd_seen));
    chk("read data", {7'h00, exp}, {7'h00, last_rd});
  endtask
  task automatic wr(input logic [3:0] a, input logic [8:0] d);
    host.send(a, 2'b00, d, 0);
    tick(2);
  endtask
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_por;
    chk("por switches", 16'hFFFF, outs);
    rd(4'h4, 9'h1FF);
    rd(4'hA, 9'h1FF);
    rd(4'h0, 9'h000);
    $display("test por done");
  endtask
  // walking zero through both registers, reserved bit written low
  task automatic t_bits;
    logic [3:0] a;
    logic [7:0] v;
    for (int r = 0; r < 2; r++) begin
      a = (r == 0) ? 4'h4 : 4'hA;
      for (int i = 0; i < 8; i++) begin
        v = 8'hFF ^ (8'h01 << i);
        wr(a, {1'b0, v});
        chk("switches", (r == 0) ? {8'hFF, v} : {v, 8'hFF}, outs);
        rd(a, {1'b1, v});
      end
      wr(a, 9'h0FF);
    end
    $display("test bits done");
  endtask
  // a slow completion must not leak the staged value early
  task automatic t_commit;
    fork
      host.send(4'h4, 2'b00, 9'h000, 6);
      begin
        tick(6);
        chk("early switches", 16'hFFFF, outs);
      end
    join
    tick(2);
    chk("late switches", 16'hFF00, outs);
    wr(4'h0, 9'h000);
    chk("wiper write", 16'hFF00, outs);
    rd(4'h4, 9'h100);
    wr(4'h4, 9'h1FF);
    $display("test commit done");
  endtask
  // with the enable low nothing moves, so a command in that time is lost
  task automatic t_ce;
    @(posedge clk) ce <= 1'b0;
    host.send(4'h4, 2'b00, 9'h000, 0);
    tick(3);
    @(posedge clk) ce <= 1'b1;
    tick(2);
    chk("frozen switches", 16'hFFFF, outs);
    rd(4'h4, 9'h1FF);
    $display("test ce done");
  endtask
  // every command at every address except writes to valid ones, then silence until deselect
  task automatic t_err;
    logic bad;
    int   n;
    for (int a = 0; a < 16; a++) begin
      for (int op = 0; op < 4; op++) begin
        bad = !(a inside {0, 1, 4, 6, 7, 10}) || ((a == 4 || a == 10) && (op == 1 || op == 2));
        if (bad || op != 0) begin
          host.send(4'(a), 2'(op), 9'h000, 0);
          tick(1);
          chk("error flag", {15'h0, bad}, {15'h0, cmd_error});
          if (bad) host.clear_err();
        end
      end
    end
    host.send(4'hA, 2'b01, 9'h000, 0);
    n = rd_seen;
    host.send(4'h4, 2'b00, 9'h000, 0);
    host.send(4'h4, 2'b11, 9'h000, 0);
    tick(10);
    chk("silent reads", 16'(n), 16'(rd_seen));
    chk("held switches", 16'hFFFF, outs);
    chk("error held", 16'h0001, {15'h0, cmd_error});
    host.clear_err();
    tick(1);
    chk("error cleared", 16'h0000, {15'h0, cmd_error});
    rd(4'h4, 9'h1FF);
    $display("test error done");
  endtask
  task automatic t_pin;
    wr(4'h4, 9'h0F0);
    wr(4'hA, 9'h0AA);
    chk("set switches", 16'hAAF0, outs);
    @(posedge clk) reset_pin_n <= 1'b0;
    tick(6);
    chk("pin default", 16'hFFFF, outs);
    host.send(4'h4, 2'b00, 9'h000, 0);
    tick(3);
    chk("pin ignores", 16'hFFFF, outs);
    @(posedge clk) reset_pin_n <= 1'b1;
    tick(4);
    rd(4'h4, 9'h1FF);
    rd(4'hA, 9'h1FF);
    $display("test pin done");
  endtask
  task automatic t_arst;
    wr(4'h4, 9'h033);
    @(posedge clk) arst_n <= 1'b0;
    tick(2);
    chk("por in run", 16'hFFFF, outs);
    @(posedge clk) arst_n <= 1'b1;
    tick(2);
    rd(4'h4, 9'h1FF);
    host.restore(9'h033, 9'h1FF);
    tick(2);
    chk("restored", 16'hFF33, outs);
    $display("test arst done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    tick(2);
    t_por;
    t_bits;
    t_commit;
    t_ce;
    t_err;
    t_pin;
    t_arst;
    print_verdict;
  end
  // a hang counts against the run
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule

// [verif/pot_terminal_ctrl_reg_props.sv]
/*
  Assertion checker for the terminal-control register block.
  Assumes one clock domain and sees only the top ports; bound in below.
*/
`timescale 1ns/1ps

module pot_terminal_ctrl_reg_props (
  input wire logic       clk, arst_n, ce, reset_pin_n, cs_pin_n, // clock, reset, pins
  input wire logic       cmd_valid, cmd_end, rd_valid, cmd_error, // strobes and state
  input wire logic [3:0] cmd_addr,                                // command address
  input wire logic [1:0] cmd_op,                                  // command kind
  input wire logic [8:0] cmd_wdata, rd_data,                      // data both ways
  input wire logic       net0_term_a_connect, net0_wiper_connect, net0_term_b_connect,
  input wire logic       net0_force_shutdown_n, net1_term_a_connect, net1_wiper_connect,
  input wire logic       net1_term_b_connect, net1_force_shutdown_n, net2_term_a_connect,
  input wire logic       net2_wiper_connect, net2_term_b_connect, net2_force_shutdown_n,
  input wire logic       net3_term_a_connect, net3_wiper_connect, net3_term_b_connect,
  input wire logic       net3_force_shutdown_n // last switch
);
  // switch outputs packed in register order, shutdown_n, A, W, B per network
  wire logic [15:0] outs = {net3_force_shutdown_n, net3_term_a_connect, net3_wiper_connect,
    net3_term_b_connect, net2_force_shutdown_n, net2_term_a_connect, net2_wiper_connect,
    net2_term_b_connect, net1_force_shutdown_n, net1_term_a_connect, net1_wiper_connect,
    net1_term_b_connect, net0_force_shutdown_n, net0_term_a_connect, net0_wiper_connect,
    net0_term_b_connect};
  wire logic terminal_ctrl_reg_a = cmd_addr == 4'h4 || cmd_addr == 4'hA;
  wire logic known_a = terminal_ctrl_reg_a || cmd_addr inside {4'h0, 4'h1, 4'h6, 4'h7};
  wire logic bad_op = cmd_op == 2'b01 || cmd_op == 2'b10;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////////////
  property p_rd_terminal_ctrl_reg;
    rd_valid && $past(cmd_addr) == 4'h4 |-> rd_data[8] && $past(cmd_op) == 2'b11;
  endproperty
  a_rd_terminal_ctrl_reg: assert property (p_rd_terminal_ctrl_reg) else $error("reserved bit read low");
  property p_rd_cause;
    rd_valid |-> $past(cmd_valid) && !$past(cmd_error);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answered in error");
  property p_err_terminal_ctrl_reg;
    ce && cmd_valid && !cmd_error && terminal_ctrl_reg_a && bad_op && reset_pin_n && $past(reset_pin_n)
      && $past(reset_pin_n, 2) |=> cmd_error;
  endproperty
  a_err_terminal_ctrl_reg: assert property (p_err_terminal_ctrl_reg) else $error("step on control reg no error");
  property p_err_rsvd;
    ce && cmd_valid && !cmd_error && !known_a && reset_pin_n && $past(reset_pin_n)
      && $past(reset_pin_n, 2) |=> cmd_error;
  endproperty
  a_err_rsvd: assert property (p_err_rsvd) else $error("reserved address no error");
  property p_err_hold;
    cmd_error && !cs_pin_n && !$past(cs_pin_n) && !$past(cs_pin_n, 2) && reset_pin_n
      && $past(reset_pin_n) && $past(reset_pin_n, 2) |=> cmd_error;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error left with select low");
  property p_err_clear;
    $past(ce) && $past(cs_pin_n, 3) && $past(cs_pin_n, 4) && !$past(cmd_valid) |-> !cmd_error;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error kept after deselect");
  property p_commit;
    $changed(outs) |-> $past(cmd_end, 2) || !$past(reset_pin_n, 3) || !$past(reset_pin_n, 4)
      || !$past(reset_pin_n, 5);
  endproperty
  a_commit: assert property (p_commit) else $error("switches moved without commit");
  property p_pin_def;
    !reset_pin_n && !$past(reset_pin_n) && !$past(reset_pin_n, 2) && !$past(reset_pin_n, 3)
      && !$past(reset_pin_n, 4) |-> outs == 16'hFFFF;
  endproperty
  a_pin_def: assert property (p_pin_def) else $error("reset pin left switches");
  property p_pin_mute;
    !$past(reset_pin_n, 2) && !$past(reset_pin_n, 3) |-> !rd_valid && !cmd_error;
  endproperty
  a_pin_mute: assert property (p_pin_mute) else $error("reset pin did not mute");
endmodule

bind pot_terminal_control_regs pot_terminal_ctrl_reg_props u_props (.clk, .arst_n, .ce, .reset_pin_n,
  .cs_pin_n, .cmd_valid, .cmd_end, .rd_valid, .cmd_error, .cmd_addr, .cmd_op, .cmd_wdata,
  .rd_data, .net0_term_a_connect, .net0_wiper_connect, .net0_term_b_connect,
  .net0_force_shutdown_n, .net1_term_a_connect, .net1_wiper_connect, .net1_term_b_connect,
  .net1_force_shutdown_n, .net2_term_a_connect, .net2_wiper_connect, .net2_term_b_connect,
  .net2_force_shutdown_n, .net3_term_a_connect, .net3_wiper_connect, .net3_term_b_connect,
  .net3_force_shutdown_n);
